// ==== logic/rss_pkg.sv ====
`default_nettype none

package rss_pkg;

   // ---------------------------------------------------------------
   // Clock and timebase
   // ---------------------------------------------------------------
   localparam int unsigned REF_CLK_HZ = 25_000_000;
   localparam int unsigned TB_CLK_HZ  = 32_000;
   // Integer divide: the timebase runs a fraction fast (781.25 ideal)
   localparam int unsigned DIV_CYCLES = REF_CLK_HZ / TB_CLK_HZ;
   localparam int unsigned DIV_W      = 10;

   // ---------------------------------------------------------------
   // Reset lengths, in timebase periods
   // ---------------------------------------------------------------
   localparam int unsigned POR_TIME_MS   = 300;
   localparam int unsigned MS_PER_S      = 1000;
   localparam int unsigned POR_TICKS     = POR_TIME_MS * TB_CLK_HZ
                                           / MS_PER_S;
   localparam int unsigned POR_CNT_W     = 14;
   localparam int unsigned SDRAM_TICKS   = 7;
   localparam int unsigned SYS_TICKS     = 14;
   localparam int unsigned STR_CNT_W     = 4;
   localparam int unsigned QUAL_TICKS    = 4;
   localparam int unsigned QUAL_CNT_W    = 2;

   // Index of each stretched reset in the generate loop
   localparam int unsigned STR_SDRAM     = 0;
   localparam int unsigned STR_SYS       = 1;
   localparam int unsigned STR_NUM       = 2;
   localparam int unsigned STRETCH_TICKS [STR_NUM] = '{SDRAM_TICKS,
                                                      SYS_TICKS};

   // Reset values of the held flops
   localparam logic HOLD_N_RST  = 1'h0;
   localparam logic FLAG_RST    = 1'h0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RSS_Q_IDLE,
      RSS_Q_COUNT,
      RSS_Q_HELD
   } rss_qual_state_t;

   // Reset outputs, all active low
   typedef struct packed {
      logic sdram_rst_n;
      logic internal_system_reset_n;
      logic rst_out_n;
   } rss_rst_out_t;

   // Internal status, active high
   typedef struct packed {
      logic por_busy;
      logic hard_rst_qualified;
      logic hard_rst_rejected;
   } rss_status_t;

   // ---------------------------------------------------------------
   // Shared decode: counter at its last value before wrap
   // ---------------------------------------------------------------
   function automatic logic rss_at_last(input int unsigned value,
                                        input int unsigned limit);
      rss_at_last = (value == limit - 1);
   endfunction

endpackage

`default_nettype wire

// ==== logic/rss_stretch.sv ====
`default_nettype none

module rss_stretch
   import rss_pkg::*;
#(
   parameter int unsigned COUNT = SDRAM_TICKS,
   parameter int unsigned CNT_W = STR_CNT_W
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic tick,
   input  wire logic src,
   output var  logic hold_n
);

   logic [CNT_W-1:0] cnt_q;
   logic             hold_n_q;
   logic [CNT_W-1:0] meas_q;

   // ---------------------------------------------------------------
   // Stretch counter
   // ---------------------------------------------------------------
   // Source held: restart; released: count ticks, let go on the last
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q    <= '0;
         hold_n_q <= HOLD_N_RST;
      end else if (src) begin
         cnt_q    <= '0;
         hold_n_q <= HOLD_N_RST;
      end else if (!hold_n_q && tick) begin
         if (rss_at_last(int'(cnt_q), COUNT)) begin
            hold_n_q <= ~HOLD_N_RST;
         end else begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end
   end

   assign hold_n = hold_n_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Independent tally of ticks seen between release and deassertion
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meas_q <= '0;
      end else if (src) begin
         meas_q <= '0;
      end else if (!hold_n_q && tick) begin
         meas_q <= meas_q + CNT_W'(1);
      end
   end

   stretch_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(hold_n_q) |-> meas_q == CNT_W'(COUNT))
      else $error("stretched reset length wrong");

   src_holds_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      src |=> !hold_n_q)
      else $error("reset released while source held");

endmodule

`default_nettype wire

// ==== logic/rss_top.sv ====
`default_nettype none

module rss_top
   import rss_pkg::*;
#(
   parameter int unsigned POR_LEN = POR_TICKS
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         por_in_n,
   input  wire logic         hard_rst_in_n,
   output var  rss_rst_out_t rst_o,
   output var  rss_status_t  status_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [DIV_W-1:0]      div_q;
   logic                  tick_q;
   logic                  por_src;
   logic                  por_hold_n;
   logic                  hard_in;
   rss_qual_state_t       qual_q;
   rss_qual_state_t       qual_d;
   logic [QUAL_CNT_W-1:0] qual_cnt_q;
   logic                  rejected_q;
   logic                  str_src;
   logic [STR_NUM-1:0]    str_hold_n;
   logic [STR_CNT_W-1:0]  gap_q;

   // ---------------------------------------------------------------
   // Low-frequency timebase
   // ---------------------------------------------------------------
   // One-cycle enable every DIV_CYCLES; no second clock domain needed
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q  <= '0;
         tick_q <= FLAG_RST;
      end else if (rss_at_last(int'(div_q), DIV_CYCLES)) begin
         div_q  <= '0;
         tick_q <= 1'h1;
      end else begin
         div_q  <= div_q + DIV_W'(1);
         tick_q <= 1'h0;
      end
   end

   // ---------------------------------------------------------------
   // Internal power-up reset
   // ---------------------------------------------------------------
   // The board keeps the input low until the crystal runs, so the
   // count is never started on a timebase that is not yet stable
   assign por_src = ~por_in_n;

   rss_stretch #(
      .COUNT (POR_LEN),
      .CNT_W (POR_CNT_W)
   ) u_por (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick    (tick_q),
      .src     (por_src),
      .hold_n  (por_hold_n)
   );

   // ---------------------------------------------------------------
   // Hard-reset qualifier
   // ---------------------------------------------------------------
   // Board pulses shorter than the minimum width are filtered here
   assign hard_in = ~hard_rst_in_n;

   // Next state: any release drops back to idle at once
   always_comb begin
      qual_d = qual_q;
      unique case (qual_q)
         RSS_Q_IDLE: begin
            if (hard_in) begin
               qual_d = RSS_Q_COUNT;
            end
         end
         RSS_Q_COUNT: begin
            if (!hard_in) begin
               qual_d = RSS_Q_IDLE;
            end else if (tick_q &&
                         rss_at_last(int'(qual_cnt_q), QUAL_TICKS)) begin
               qual_d = RSS_Q_HELD;
            end
         end
         RSS_Q_HELD: begin
            if (!hard_in) begin
               qual_d = RSS_Q_IDLE;
            end
         end
         default: begin
            qual_d = RSS_Q_IDLE; // Unused code 2'b11
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         qual_q <= RSS_Q_IDLE;
      end else begin
         qual_q <= qual_d;
      end
   end

   // Consecutive held ticks; cleared whenever the input lets go
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         qual_cnt_q <= '0;
      end else if (qual_q != RSS_Q_COUNT) begin
         qual_cnt_q <= '0;
      end else if (tick_q && hard_in) begin
         qual_cnt_q <= qual_cnt_q + QUAL_CNT_W'(1);
      end
   end

   // One-cycle pulse when a short pulse is thrown away
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rejected_q <= FLAG_RST;
      end else begin
         rejected_q <= (qual_q == RSS_Q_COUNT) && !hard_in;
      end
   end

   // ---------------------------------------------------------------
   // Stretched resets
   // ---------------------------------------------------------------
   // Either source restarts both stretchers from zero
   assign str_src = !por_hold_n || (qual_q == RSS_Q_HELD);

   // Same structure for SDRAM and system reset, different lengths
   for (genvar g = 0; g < STR_NUM; g++) begin : g_str
      rss_stretch #(
         .COUNT (STRETCH_TICKS[g]),
         .CNT_W (STR_CNT_W)
      ) u_str (
         .ref_clk (ref_clk),
         .rst_n   (rst_n),
         .tick    (tick_q),
         .src     (str_src),
         .hold_n  (str_hold_n[g])
      );
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // All bits come from the stretcher and qualifier flops, the qualified flag through a state decode;
   // the pin shares the system reset flop so the two never skew
   assign rst_o.sdram_rst_n             = str_hold_n[STR_SDRAM];
   assign rst_o.internal_system_reset_n = str_hold_n[STR_SYS];
   assign rst_o.rst_out_n               = str_hold_n[STR_SYS];
   assign status_o.por_busy             = !por_hold_n;
   assign status_o.hard_rst_qualified   = (qual_q == RSS_Q_HELD);
   assign status_o.hard_rst_rejected    = rejected_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (!rst_n);

   // Ticks from SDRAM release to system release must match the gap
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q <= '0;
      end else if (!str_hold_n[STR_SDRAM]) begin
         gap_q <= '0;
      end else if (tick_q && !str_hold_n[STR_SYS]) begin
         gap_q <= gap_q + STR_CNT_W'(1);
      end
   end

   // Entry to held needs the fourth tick with the input still low
   sequence s_fourth_tick;
      (qual_q == RSS_Q_COUNT) && hard_in && tick_q &&
      (qual_cnt_q == QUAL_CNT_W'(QUAL_TICKS - 1));
   endsequence

   sequence s_short_drop;
      (qual_q == RSS_Q_COUNT) && !hard_in;
   endsequence

   qual_entry_a: assert property (
      $rose(qual_q == RSS_Q_HELD) |-> $past((qual_q == RSS_Q_COUNT) &&
      hard_in && tick_q &&
      (qual_cnt_q == QUAL_CNT_W'(QUAL_TICKS - 1))))
      else $error("hard reset qualified too early");

   qual_accept_a: assert property (
      s_fourth_tick |=> qual_q == RSS_Q_HELD)
      else $error("held hard reset not qualified");

   short_reject_a: assert property (
      s_short_drop |=> rejected_q && (qual_q == RSS_Q_IDLE))
      else $error("short hard reset not rejected");

   qual_release_a: assert property (
      (qual_q == RSS_Q_HELD) && !hard_in |=> qual_q == RSS_Q_IDLE)
      else $error("qualifier stuck after release");

   sys_gap_a: assert property (
      $rose(rst_o.internal_system_reset_n) |->
      gap_q == STR_CNT_W'(SYS_TICKS - SDRAM_TICKS))
      else $error("system reset gap after SDRAM wrong");

   por_blocks_a: assert property (
      !por_hold_n |=> !rst_o.sdram_rst_n && !rst_o.rst_out_n)
      else $error("reset released during power-up hold");

   pin_tracks_a: assert property (
      $rose(rst_o.rst_out_n) |-> $rose(rst_o.internal_system_reset_n) &&
      $past(tick_q))
      else $error("reset pin and system reset differ");

   sdram_first_a: assert property (
      $rose(rst_o.sdram_rst_n) |-> $past(tick_q) && !str_src &&
      !rst_o.internal_system_reset_n)
      else $error("SDRAM reset released out of order");

   tick_period_a: assert property (
      tick_q |=> !tick_q [*8])
      else $error("timebase enable too frequent");

endmodule

`default_nettype wire

// ==== testbench/rss_board_src.sv ====
`default_nettype none

// ---------------------------------------------------------------
// Board reset sources: power-up circuit and external hard reset
// ---------------------------------------------------------------
module rss_board_src (
   input  wire logic ref_clk,
   output var  logic por_in_n,
   output var  logic hard_rst_in_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // Power-up held low from time zero until the oscillator is up
   initial begin
      por_in_n      = 1'h0;
      hard_rst_in_n = 1'h1;
   end

   // Called once the bench decides the timebase has started
   task automatic por_release();
      @(negedge ref_clk);
      por_in_n = 1'h1;
   endtask

   // Hard reset is a plain level; the caller sets the width in cycles
   // and may go below the minimum only when it wants a refusal
   task automatic hard_level(input logic lvl);
      @(negedge ref_clk);
      hard_rst_in_n = lvl;
   endtask
endmodule

`default_nettype wire

// ==== testbench/reset_stretch_sequencer_tb_top.sv ====
`default_nettype none

module reset_stretch_sequencer_tb_top
   import rss_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   // Short power-up count keeps the run well inside the cycle budget
   localparam int unsigned POR_SIM = 3;
   localparam int          LIMIT   = 40000;

   typedef struct {
      int         cyc;
      logic [5:0] val;
   } rss_note_t;

   logic         ref_clk;
   logic         rst_n;
   logic         por_in_n;
   logic         hard_rst_in_n;
   rss_rst_out_t rst_o;
   rss_status_t  status_o;
   int           cyc;
   int           err_total;
   int           tests_run;
   int           k0;
   logic [5:0]   prev_q;
   rss_note_t    notes[$];
   rss_note_t    n;

   rss_top #(.POR_LEN(POR_SIM)) i_dut (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .por_in_n      (por_in_n),
      .hard_rst_in_n (hard_rst_in_n),
      .rst_o         (rst_o),
      .status_o      (status_o)
   );

   rss_board_src i_src (
      .ref_clk       (ref_clk),
      .por_in_n      (por_in_n),
      .hard_rst_in_n (hard_rst_in_n)
   );

   // ---------------------------------------------------------------
   // Clock, cycle count since reset release, hang guard
   // ---------------------------------------------------------------
   initial ref_clk = 1'h0;
   always #20 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         cyc <= 0;
      end else begin
         cyc <= cyc + 1;
      end
      if (cyc > LIMIT) begin
         err_total++;
         end_sim();
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic int tk(input int i);
      tk = i * int'(DIV_CYCLES);
   endfunction

   task automatic note(input int c, input logic [5:0] v);
      notes.push_back('{c, v});
   endtask

   task automatic wait_to(input int c);
      while (cyc < c) @(negedge ref_clk);
   endtask

   task automatic chk_word(input string nm, input logic [5:0] e,
                           input logic [5:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One cycle of slack allows for the flop stage behind each flag;
   // a slip of a whole timebase period is still caught
   task automatic chk_cyc(input string nm, input int e, input int g);
      tests_run++;
      if (g > e + 1 || g + 1 < e) begin
         err_total++;
         $display("Error %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Watcher: every output change consumes the oldest note
   // ---------------------------------------------------------------
   always @(negedge ref_clk) begin
      if (!rst_n) begin
         prev_q = {rst_o, status_o};
      end else if ({rst_o, status_o} !== prev_q) begin
         prev_q = {rst_o, status_o};
         if (notes.size() == 0) begin
            chk_word("spare_change", 6'h00, prev_q);
         end else begin
            n = notes.pop_front();
            chk_word("outputs", n.val, prev_q);
            chk_cyc("change_edge", n.cyc, cyc);
         end
      end
   end

   // ---------------------------------------------------------------
   // Main sequence, inputs changed on falling edges only
   // ---------------------------------------------------------------
   initial begin
      rst_n     = 1'h0;
      err_total = 0;
      tests_run = 0;
      cyc       = 0;
      void'($urandom(94637));
      repeat (10) @(negedge ref_clk);
      chk_word("reset_value", {3'h0, 3'h4}, {rst_o, status_o});
      rst_n = 1'h1;
      // Power-up release, then stretched releases 7 and 14 ticks later
      wait_to(100);
      i_src.por_release();
      k0 = (cyc + 1) / int'(DIV_CYCLES);
      note(tk(k0 + POR_SIM), {3'h0, 3'h0});
      note(tk(k0 + POR_SIM + 7), {3'h4, 3'h0});
      note(tk(k0 + POR_SIM + 14), {3'h7, 3'h0});
      // Pulse three ticks long, random phase: refused
      wait_to(tk(18) + 5 + int'($urandom % 700));
      i_src.hard_level(1'h0);
      wait_to(tk(21) + 5);
      i_src.hard_level(1'h1);
      note(tk(21) + 7, {3'h7, 3'h1});
      note(tk(21) + 8, {3'h7, 3'h0});
      // Pulse of exactly four ticks: accepted, then stretched again
      wait_to(tk(23) + 5 + int'($urandom % 700));
      i_src.hard_level(1'h0);
      note(tk(27), {3'h7, 3'h2});
      note(tk(27) + 1, {3'h0, 3'h2});
      wait_to(tk(27) + 30);
      i_src.hard_level(1'h1);
      note(tk(27) + 31, {3'h0, 3'h0});
      note(tk(34), {3'h4, 3'h0});
      note(tk(41), {3'h7, 3'h0});
      wait_to(tk(41) + 20);
      chk_word("notes_left", 6'h00, 6'(notes.size()));
      end_sim();
   end
endmodule

`default_nettype wire
